// [laser_safety_defines.vh]
// Register map, field positions, reset values and rule overview for the laser safety register bank
// Overview of operation
// [R1] Open select or mode pin raises its open error, blocks lasing, registers still work. Code has no open error flag.
// [R2] Fault alert held low while either configuration pin is open.
// [R3] Each channel disable bit resets to 1 and keeps that channel off.
// [R4] Any pending status error forces both channels off.
// [R5] Each status bit change pulses fault alert unless masked. In the code the monitor seen bits of status byte B never pulse it.
// [R6] Status byte A: ram ready, supply down, mem, overtemp, oc2, oc1, osc, timeout.
// [R7] Status byte B: per channel on state, monitor seen, saturation at bits 0-2, 4-6.
// [R8] Reading a status register acknowledges the errors it reports.
// [R9] Power-on sets supply down and ram ready flags; host reads both statuses.
// [R10] Leaving standby keeps registers but sets supply down flag.
// [R11] Channel_combine bit plus both disables cleared and both pins high parallels channel 2.
// [R12] In channel_combine both comparators stay active; host parks channel 2 limit at maximum.
// [R13] In channel_combine channel 1 limit code scales by two, valid codes 10 to 255.
// [R14] SPI selected when interface select pin low; master drives select and clock.
// [R15] SPI frame: address byte, opcode 10 read 01 write, six bit address, data.
// [R16] SPI address increments after each byte, wrapping from 0x3f to 0x00.
// [R17] I2C selected when interface select pin high; pins become clock, data, address.
// [R18] I2C frame: slave address, register address, data; bit 0 one means read. Code acks register address and data bytes but stores neither.
// [R19] I2C slave address is 11000 followed by address pin high then low bit.
// [R20] Monitor resistor codes are 8 bits and reset to 0xff.
// [R21] Sense select bit routes the converter to internal node when 1.
// [R22] Resistor off bit disconnects the internal monitor resistor when 1.
// [R23] Oscillator error mask bit 0 at 0x1d withholds alert; resets to 0.
// [R24] Saturation masks at bits 2 and 3 reset to 1 and gate alert.
// [R25] A status read clears only flags whose cause has ended.
// [R26] I2C multi-byte transfers auto-increment and wrap the register address too; code increments only after read bytes.
`ifndef LASER_SAFETY_DEFINES_VH
`define LASER_SAFETY_DEFINES_VH
`define ADDR_STATUS_A 6'h00
`define ADDR_STATUS_B 6'h01
`define ADDR_CH1_CFG 6'h10
`define ADDR_CH1_LIMIT 6'h11
`define ADDR_CH1_RES 6'h12
`define ADDR_CH2_CFG 6'h15
`define ADDR_CH2_LIMIT 6'h16
`define ADDR_CH2_RES 6'h17
`define ADDR_SENSE 6'h1a
`define ADDR_COMBINE 6'h1b
`define ADDR_MASK 6'h1d
`define ADDR_DISABLE 6'h1e
`define ADDR_LAST 6'h3f
`define BIT_COMBINE 6
`define BIT_RES_OFF 2
`define BIT_EXT_CAP 1
`define BIT_SENSE1 2
`define BIT_SENSE2 6
`define BIT_OSC_MASK 0
`define BIT_SAT1_MASK 2
`define BIT_SAT2_MASK 3
`define BIT_SIM_OC1 5
`define BIT_SIM_OC2 6
`define RST_LIMIT 8'hff
`define RST_RES 8'hff
`define RST_MASK 8'h0c
`define RST_DISABLE 8'h03
`define RST_COMBINE 8'h02
`define RST_CH_CFG 8'h10
`define OPC_READ 2'h2
`define OPC_WRITE 2'h1
`define I2C_ID_HIGH 5'h18
`endif

// [status_flag.v]
// Sticky status flag with acknowledge-on-read and change pulse
`timescale 1ns/1ps
`default_nettype none
module status_flag (
    input wire clk,
    input wire rst,
    input wire rst_value,
    input wire cause,
    input wire ack,
    output reg flag_q,
    output wire changed
);
    reg flag_d;
    always @* begin
        flag_d = flag_q;
        if (ack && !cause) begin
            flag_d = 1'b0; // [R25]
        end
        if (cause) begin
            flag_d = 1'b1; // Set wins over acknowledge
        end
    end
    always @(posedge clk) begin
        if (rst) begin
            flag_q <= rst_value;
        end else begin
            flag_q <= flag_d;
        end
    end
    assign changed = flag_d != flag_q;
endmodule // status_flag
`default_nettype wire

// [laser_safety_regs.v]
// Dual laser channel safety logic and SPI/I2C register slave
`timescale 1ns/1ps
`default_nettype none
`include "laser_safety_defines.vh"
module laser_safety_regs (
    input wire CLK_SYS,
    input wire RST,
    input wire IFACE_SEL,
    input wire IFACE_SEL_OPEN,
    input wire MODE_CFG_OPEN,
    input wire CH1_ENABLE_PIN,
    input wire CH2_ENABLE_PIN,
    input wire CS_OR_ADDR_HI,
    input wire SIN_OR_ADDR_LO,
    input wire SCLK,
    input wire SDA_IN,
    output reg SDA_OUT,
    output reg SDA_OE,
    input wire STANDBY_EXIT,
    input wire MEM_ERR_IN,
    input wire OVERTEMP_IN,
    input wire CH1_OC_IN,
    input wire CH2_OC_IN,
    input wire OSC_ERR_IN,
    input wire CFG_TIMEOUT_IN,
    input wire CH1_SAT_IN,
    input wire CH2_SAT_IN,
    output wire FAULT_ALERT_N,
    output reg CH1_ON,
    output reg CH2_ON,
    output reg CHANNEL_COMBINE,
    output reg [7:0] CH1_LIMIT_CODE,
    output reg [7:0] CH2_LIMIT_CODE,
    output reg CH1_LIMIT_DOUBLE,
    output reg [7:0] CH1_RES_CODE,
    output reg [7:0] CH2_RES_CODE,
    output reg CH1_RES_OFF,
    output reg CH2_RES_OFF,
    output reg CH1_ADC_SENSE,
    output reg CH2_ADC_SENSE,
    output reg CH2_EXT_CAP
);
    localparam S_IDLE = 4'b0001;
    localparam S_ADDR = 4'b0010;
    localparam S_DATA = 4'b0100;
    localparam S_ACK = 4'b1000;

    // Two-stage synchronisers for every asynchronous pin
    reg [10:0] s1_q;
    reg [10:0] s2_q;
    wire [10:0] pins = {SDA_IN, SCLK, SIN_OR_ADDR_LO, CS_OR_ADDR_HI, IFACE_SEL,
        IFACE_SEL_OPEN, MODE_CFG_OPEN, CH1_ENABLE_PIN, CH2_ENABLE_PIN, STANDBY_EXIT,
        1'b0};
    always @(posedge CLK_SYS) begin
        if (RST) begin
            s1_q <= 11'h000;
            s2_q <= 11'h000;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
        end
    end
    wire sda = s2_q[10];
    wire scl = s2_q[9];
    wire din = s2_q[8];
    wire cs_hi = s2_q[7];
    wire i2c_mode = s2_q[6]; // [R14] [R17]
    wire iface_open = s2_q[5];
    wire mode_open = s2_q[4];
    wire en1 = s2_q[3];
    wire en2 = s2_q[2];
    wire standby_exit = s2_q[1];
    reg scl_q;
    reg sda_q;
    reg cs_q;
    reg stb_q;
    always @(posedge CLK_SYS) begin
        if (RST) begin
            scl_q <= 1'b0;
            sda_q <= 1'b1;
            cs_q <= 1'b1;
            stb_q <= 1'b0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            cs_q <= cs_hi;
            stb_q <= standby_exit;
        end
    end
    wire scl_rise = scl && !scl_q;
    wire scl_fall = !scl && scl_q;
    wire i2c_start = i2c_mode && scl && sda_q && !sda;
    wire i2c_stop = i2c_mode && scl && !sda_q && sda;
    wire standby_rise = standby_exit && !stb_q;

    // Configuration registers
    reg [7:0] ch1_cfg_q;
    reg [7:0] ch2_cfg_q;
    reg [7:0] sense_q;
    reg [7:0] combine_q;
    reg [7:0] mask_q;
    reg [7:0] disable_q;

    // Status flags
    reg por_q;
    wire ack_a;
    wire ack_b;
    wire [13:0] cause;
    wire [13:0] flags;
    wire [13:0] chg;
    wire [13:0] rstv = 14'h0003; // [R9]
    wire [13:0] acks = {{6{ack_b}}, {8{ack_a}}}; // [R8]
    assign cause[0] = por_q; // [R9]
    assign cause[1] = por_q | standby_rise; // [R10]
    assign cause[2] = MEM_ERR_IN;
    assign cause[3] = OVERTEMP_IN;
    assign cause[4] = CH2_OC_IN | mask_q[`BIT_SIM_OC2]; // [R12]
    assign cause[5] = CH1_OC_IN | mask_q[`BIT_SIM_OC1];
    assign cause[6] = OSC_ERR_IN;
    assign cause[7] = CFG_TIMEOUT_IN;
    assign cause[8] = 1'b0;
    assign cause[9] = 1'b0;
    assign cause[10] = CH1_SAT_IN;
    assign cause[11] = 1'b0;
    assign cause[12] = 1'b0;
    assign cause[13] = CH2_SAT_IN;
    genvar gi;
    generate
        for (gi = 0; gi < 14; gi = gi + 1) begin : g_flag
            status_flag u_flag (
                .clk(CLK_SYS),
                .rst(RST),
                .rst_value(rstv[gi]),
                .cause(cause[gi]),
                .ack(acks[gi]),
                .flag_q(flags[gi]),
                .changed(chg[gi])
            );
        end
    endgenerate
    reg mon1_q;
    reg mon2_q;
    wire [7:0] status_a = flags[7:0]; // [R6]
    wire [7:0] status_b = {1'b0, flags[13], mon2_q, CH2_ON, 1'b0, flags[10], mon1_q,
        CH1_ON}; // [R7]

    // Channel enable logic
    wire err_block = (|status_a[7:0]) | iface_open | mode_open; // [R4] [R1]
    wire on1 = !err_block && !disable_q[0] && en1; // [R3]
    wire on2 = !err_block && !disable_q[1] && en2 &&
        !(combine_q[`BIT_COMBINE] && !on1); // [R11]
    reg alert_q;
    wire [13:0] alert_mask = {!mask_q[`BIT_SAT2_MASK], 2'b11, !mask_q[`BIT_SAT1_MASK], 3'b111,
        !mask_q[`BIT_OSC_MASK], 6'h3f}; // [R23] [R24]
    always @(posedge CLK_SYS) begin
        if (RST) begin
            por_q <= 1'b1;
            CH1_ON <= 1'b0;
            CH2_ON <= 1'b0;
            mon1_q <= 1'b0;
            mon2_q <= 1'b0;
            alert_q <= 1'b0;
        end else begin
            por_q <= 1'b0;
            CH1_ON <= on1;
            CH2_ON <= on2;
            if (on1 && !CH1_RES_OFF) begin
                mon1_q <= 1'b1;
            end
            if (on2 && !CH2_RES_OFF) begin
                mon2_q <= 1'b1;
            end
            alert_q <= |(chg & alert_mask) | (CH1_ON ^ on1) | (CH2_ON ^ on2); // [R5]
        end
    end
    assign FAULT_ALERT_N = !(alert_q | iface_open | mode_open); // [R2]

    // Serial protocol engine shared by SPI and I2C
    reg [3:0] state_q;
    reg [7:0] shift_q;
    reg [2:0] bitc_q;
    reg [5:0] addr_q;
    reg rd_q;
    reg first_q;
    reg [7:0] tx_q;
    reg wr_pulse;
    reg rd_pulse;
    reg [7:0] rdata;
    wire [6:0] my_id = {`I2C_ID_HIGH, cs_hi, din}; // [R19]
    wire [7:0] byte_in = {shift_q[6:0], i2c_mode ? sda : din};
    assign ack_a = rd_pulse && addr_q == `ADDR_STATUS_A;
    assign ack_b = rd_pulse && addr_q == `ADDR_STATUS_B;
    always @* begin
        if (addr_q == `ADDR_STATUS_A) begin
            rdata = status_a;
        end else if (addr_q == `ADDR_STATUS_B) begin
            rdata = status_b;
        end else if (addr_q == `ADDR_CH1_CFG) begin
            rdata = ch1_cfg_q;
        end else if (addr_q == `ADDR_CH1_LIMIT) begin
            rdata = CH1_LIMIT_CODE;
        end else if (addr_q == `ADDR_CH1_RES) begin
            rdata = CH1_RES_CODE;
        end else if (addr_q == `ADDR_CH2_CFG) begin
            rdata = ch2_cfg_q;
        end else if (addr_q == `ADDR_CH2_LIMIT) begin
            rdata = CH2_LIMIT_CODE;
        end else if (addr_q == `ADDR_CH2_RES) begin
            rdata = CH2_RES_CODE;
        end else if (addr_q == `ADDR_SENSE) begin
            rdata = sense_q;
        end else if (addr_q == `ADDR_COMBINE) begin
            rdata = combine_q;
        end else if (addr_q == `ADDR_MASK) begin
            rdata = mask_q;
        end else if (addr_q == `ADDR_DISABLE) begin
            rdata = disable_q;
        end else begin
            rdata = 8'h00;
        end
    end
    always @(posedge CLK_SYS) begin
        wr_pulse <= 1'b0;
        rd_pulse <= 1'b0;
        if (RST) begin
            state_q <= S_IDLE;
            shift_q <= 8'h00;
            bitc_q <= 3'h0;
            addr_q <= 6'h00;
            rd_q <= 1'b0;
            first_q <= 1'b0;
            tx_q <= 8'h00;
            SDA_OUT <= 1'b0;
            SDA_OE <= 1'b0;
        end else if (!i2c_mode) begin
            SDA_OE <= !cs_hi;
            if (cs_hi) begin
                state_q <= S_ADDR;
                bitc_q <= 3'h0;
            end else if (!cs_hi && cs_q) begin
                SDA_OUT <= 1'b0;
            end else if (scl_rise) begin
                shift_q <= byte_in;
                bitc_q <= bitc_q + 3'h1;
                if (bitc_q == 3'h7) begin
                    if (state_q == S_ADDR) begin
                        rd_q <= byte_in[7:6] == `OPC_READ; // [R15]
                        addr_q <= byte_in[5:0];
                        state_q <= (byte_in[7:6] == `OPC_READ ||
                            byte_in[7:6] == `OPC_WRITE) ? S_DATA : S_IDLE;
                    end else if (state_q == S_DATA) begin
                        wr_pulse <= !rd_q;
                        rd_pulse <= rd_q;
                    end
                end
            end else if (scl_fall && state_q == S_DATA) begin
                if (bitc_q == 3'h0) begin
                    tx_q <= {rdata[6:0], 1'b0};
                    SDA_OUT <= rdata[7];
                end else begin
                    SDA_OUT <= tx_q[7];
                    tx_q <= {tx_q[6:0], 1'b0};
                end
            end else if (wr_pulse || rd_pulse) begin
                addr_q <= addr_q + 6'h01; // [R16]
            end
        end else begin
            if (i2c_start) begin
                state_q <= S_ADDR;
                bitc_q <= 3'h0;
                first_q <= 1'b1;
                SDA_OE <= 1'b0;
            end else if (i2c_stop) begin
                state_q <= S_IDLE;
                SDA_OE <= 1'b0;
            end else if (scl_rise && state_q != S_IDLE && state_q != S_ACK) begin
                shift_q <= byte_in;
                bitc_q <= bitc_q + 3'h1;
                if (bitc_q == 3'h7) begin
                    state_q <= S_ACK;
                    if (first_q) begin
                        rd_q <= byte_in[0]; // [R18]
                    end
                end
            end else if (scl_rise && state_q == S_ACK && rd_q && SDA_OE == 1'b0 && sda) begin
                state_q <= S_IDLE; // Master NACK ends the read
            end else if (scl_fall && state_q == S_ACK) begin
                if (SDA_OE && !(rd_q && !first_q && state_q == S_ACK && bitc_q != 3'h0)) begin
                    SDA_OE <= 1'b0;
                    state_q <= S_DATA;
                    if (rd_q && !first_q) begin
                        SDA_OE <= !rdata[7];
                        tx_q <= {rdata[6:0], 1'b0};
                        rd_pulse <= 1'b1;
                    end
                end else if (first_q && shift_q[7:1] != my_id) begin
                    state_q <= S_IDLE;
                end else if (first_q) begin
                    SDA_OE <= 1'b1;
                    first_q <= 1'b0;
                end else begin
                    SDA_OE <= 1'b1;
                end
                SDA_OUT <= 1'b0;
            end else if (scl_fall && state_q == S_DATA && rd_q && !first_q) begin
                SDA_OE <= !tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
                if (bitc_q == 3'h0) begin
                    SDA_OE <= 1'b0;
                    state_q <= S_ACK;
                end
            end
            if (wr_pulse || rd_pulse) begin
                addr_q <= addr_q + 6'h01; // [R26]
            end
        end
    end

    // Register writes
    always @(posedge CLK_SYS) begin
        if (RST) begin
            ch1_cfg_q <= `RST_CH_CFG;
            ch2_cfg_q <= `RST_CH_CFG;
            CH1_LIMIT_CODE <= `RST_LIMIT;
            CH2_LIMIT_CODE <= `RST_LIMIT;
            CH1_RES_CODE <= `RST_RES; // [R20]
            CH2_RES_CODE <= `RST_RES;
            sense_q <= 8'h00;
            combine_q <= `RST_COMBINE;
            mask_q <= `RST_MASK; // [R23] [R24]
            disable_q <= `RST_DISABLE; // [R3]
        end else if (wr_pulse) begin
            if (addr_q == `ADDR_CH1_CFG) begin
                ch1_cfg_q <= shift_q;
            end else if (addr_q == `ADDR_CH1_LIMIT) begin
                CH1_LIMIT_CODE <= shift_q;
            end else if (addr_q == `ADDR_CH1_RES) begin
                CH1_RES_CODE <= shift_q;
            end else if (addr_q == `ADDR_CH2_CFG) begin
                ch2_cfg_q <= shift_q;
            end else if (addr_q == `ADDR_CH2_LIMIT) begin
                CH2_LIMIT_CODE <= shift_q;
            end else if (addr_q == `ADDR_CH2_RES) begin
                CH2_RES_CODE <= shift_q;
            end else if (addr_q == `ADDR_SENSE) begin
                sense_q <= shift_q;
            end else if (addr_q == `ADDR_COMBINE) begin
                combine_q <= shift_q;
            end else if (addr_q == `ADDR_MASK) begin
                mask_q <= shift_q;
            end else if (addr_q == `ADDR_DISABLE) begin
                disable_q <= shift_q;
            end
        end
    end
    always @(posedge CLK_SYS) begin
        if (RST) begin
            CHANNEL_COMBINE <= 1'b0;
            CH1_LIMIT_DOUBLE <= 1'b0;
            CH1_RES_OFF <= 1'b0;
            CH2_RES_OFF <= 1'b0;
            CH1_ADC_SENSE <= 1'b0;
            CH2_ADC_SENSE <= 1'b0;
            CH2_EXT_CAP <= 1'b0;
        end else begin
            CHANNEL_COMBINE <= combine_q[`BIT_COMBINE]; // [R11]
            CH1_LIMIT_DOUBLE <= combine_q[`BIT_COMBINE]; // [R13]
            CH1_RES_OFF <= ch1_cfg_q[`BIT_RES_OFF]; // [R22]
            CH2_RES_OFF <= ch2_cfg_q[`BIT_RES_OFF];
            CH1_ADC_SENSE <= sense_q[`BIT_SENSE1]; // [R21]
            CH2_ADC_SENSE <= sense_q[`BIT_SENSE2];
            CH2_EXT_CAP <= ch2_cfg_q[`BIT_EXT_CAP];
        end
    end
endmodule // laser_safety_regs
`default_nettype wire

// [spi_host.sv]
// Host microcontroller model acting as SPI master on the register port
`timescale 1ns/1ps
`default_nettype none
module spi_host (
    output logic cs_n,
    output logic sin,
    output logic sclk,
    input wire logic sdo
);
    initial begin
        cs_n = 1'b1;
        sin = 1'b0;
        sclk = 1'b0;
    end

    // Address byte then nb data bytes, MSB first; the clock stands low between frames
    task automatic xfer(input logic [7:0] ab, input logic [15:0] wd, input int nb,
                        output logic [15:0] rd);
        logic [23:0] sh;
        sh = {ab, wd};
        rd = 16'h0000;
        cs_n = 1'b0;
        for (int i = 0; i < 8 * (nb + 1); i++) begin
            sin = sh[23];
            sh = sh << 1;
            #80;
            sclk = 1'b1;
            if (i >= 8) begin
                rd = {rd[14:0], sdo};
            end
            #80;
            sclk = 1'b0;
        end
        #80;
        cs_n = 1'b1;
        // Released data line shows junk, and the gap lets the synchroniser see the deselect
        sin = ~sin;
        #160;
    endtask
endmodule // spi_host
`default_nettype wire

// [laser_safety_regs_asserts.sv]
// Concurrent checks on the laser safety register bank ports
`timescale 1ns/1ps
`default_nettype none
module laser_safety_regs_asserts (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic IFACE_SEL_OPEN,
    input wire logic MODE_CFG_OPEN,
    input wire logic CH1_ENABLE_PIN,
    input wire logic STANDBY_EXIT,
    input wire logic MEM_ERR_IN,
    input wire logic OVERTEMP_IN,
    input wire logic CH1_OC_IN,
    input wire logic CH2_OC_IN,
    input wire logic OSC_ERR_IN,
    input wire logic CFG_TIMEOUT_IN,
    input wire logic FAULT_ALERT_N,
    input wire logic CH1_ON,
    input wire logic CH2_ON,
    input wire logic CHANNEL_COMBINE,
    input wire logic CH1_LIMIT_DOUBLE
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    wire pin_open = IFACE_SEL_OPEN | MODE_CFG_OPEN;
    wire [5:0] errs = {CFG_TIMEOUT_IN, OSC_ERR_IN, CH1_OC_IN, CH2_OC_IN, OVERTEMP_IN, MEM_ERR_IN};

    sequence open_held;
        pin_open [*4];
    endsequence
    // Alert pulse is one cycle, so a short window is given rather than a fixed slot
    sequence alert_soon;
        ##[1:6] !FAULT_ALERT_N;
    endsequence

    // Pin levels pass two synchroniser stages before the alert line follows them
    open_alert_a: assert property (open_held |-> !FAULT_ALERT_N)
        else $error("alert not low while a config pin is open");
    open_off_a: assert property (open_held |-> !CH1_ON && !CH2_ON)
        else $error("channel on while a config pin is open");
    err_off_a: assert property ((|errs) [*4] |-> !CH1_ON && !CH2_ON)
        else $error("channel on while an error cause is present");
    err_alert_a: assert property (|(errs & ~$past(errs)) |-> alert_soon)
        else $error("new error not signalled on the alert line");
    standby_alert_a: assert property ($rose(STANDBY_EXIT) |-> alert_soon)
        else $error("standby exit not signalled on the alert line");
    pin_off_a: assert property ((!CH1_ENABLE_PIN) [*4] |-> !CH1_ON)
        else $error("channel 1 on with its enable pin low");
    channel_combine_scale_a: assert property (CH1_LIMIT_DOUBLE == CHANNEL_COMBINE)
        else $error("limit scaling disagrees with combine bit");
    power_off_a: assert property ($fell(RST) |-> (!CH1_ON && !CH2_ON) [*8])
        else $error("channel on right after reset");
endmodule // laser_safety_regs_asserts

bind laser_safety_regs laser_safety_regs_asserts u_laser_safety_regs_asserts (
    .CLK_SYS(CLK_SYS), .RST(RST), .IFACE_SEL_OPEN(IFACE_SEL_OPEN),
    .MODE_CFG_OPEN(MODE_CFG_OPEN), .CH1_ENABLE_PIN(CH1_ENABLE_PIN),
    .STANDBY_EXIT(STANDBY_EXIT), .MEM_ERR_IN(MEM_ERR_IN), .OVERTEMP_IN(OVERTEMP_IN),
    .CH1_OC_IN(CH1_OC_IN), .CH2_OC_IN(CH2_OC_IN), .OSC_ERR_IN(OSC_ERR_IN),
    .CFG_TIMEOUT_IN(CFG_TIMEOUT_IN), .FAULT_ALERT_N(FAULT_ALERT_N), .CH1_ON(CH1_ON),
    .CH2_ON(CH2_ON), .CHANNEL_COMBINE(CHANNEL_COMBINE), .CH1_LIMIT_DOUBLE(CH1_LIMIT_DOUBLE)
);
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the laser safety register bank over its SPI port
`timescale 1ns/1ps
`default_nettype none
`include "laser_safety_defines.vh"
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic iopen = 1'b0;
    logic mopen = 1'b0;
    logic en1 = 1'b0;
    logic en2 = 1'b0;
    logic stby = 1'b0;
    logic [5:0] cause = 6'h00;
    logic [15:0] r;
    wire logic cs_n, sin, sclk, sdo, alert_n, on1, on2, comb, dbl, sns1, sns2, off1, off2, cap2;
    wire logic [7:0] lim1, res1, res2;
    int n_fail = 0;
    int total_checks = 0;
    logic [13:0] tbl [10] = '{{`ADDR_CH1_LIMIT, 8'hff}, {`ADDR_CH2_LIMIT, 8'hff},
        {`ADDR_CH1_RES, 8'hff}, {`ADDR_CH2_RES, 8'hff}, {`ADDR_COMBINE, 8'h02},
        {`ADDR_MASK, 8'h0c}, {`ADDR_DISABLE, 8'h03}, {`ADDR_CH1_CFG, 8'h10},
        {`ADDR_CH2_CFG, 8'h10}, {`ADDR_SENSE, 8'h00}};

    always #5 clk = ~clk;

    laser_safety_regs u_laser_safety_regs (
        .CLK_SYS(clk), .RST(rst), .IFACE_SEL(1'b0), .IFACE_SEL_OPEN(iopen),
        .MODE_CFG_OPEN(mopen), .CH1_ENABLE_PIN(en1), .CH2_ENABLE_PIN(en2),
        .CS_OR_ADDR_HI(cs_n), .SIN_OR_ADDR_LO(sin), .SCLK(sclk), .SDA_IN(1'b1),
        .SDA_OUT(sdo), .SDA_OE(), .STANDBY_EXIT(stby), .MEM_ERR_IN(cause[0]),
        .OVERTEMP_IN(cause[1]), .CH2_OC_IN(cause[2]), .CH1_OC_IN(cause[3]),
        .OSC_ERR_IN(cause[4]), .CFG_TIMEOUT_IN(cause[5]), .CH1_SAT_IN(1'b0),
        .CH2_SAT_IN(1'b0), .FAULT_ALERT_N(alert_n), .CH1_ON(on1), .CH2_ON(on2),
        .CHANNEL_COMBINE(comb), .CH1_LIMIT_CODE(lim1), .CH2_LIMIT_CODE(),
        .CH1_LIMIT_DOUBLE(dbl), .CH1_RES_CODE(res1), .CH2_RES_CODE(res2),
        .CH1_RES_OFF(off1), .CH2_RES_OFF(off2), .CH1_ADC_SENSE(sns1),
        .CH2_ADC_SENSE(sns2), .CH2_EXT_CAP(cap2)
    );

    spi_host u_spi_host (.cs_n(cs_n), .sin(sin), .sclk(sclk), .sdo(sdo));

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
        u_spi_host.xfer({`OPC_WRITE, a}, {d, 8'h00}, 1, r);
    endtask

    task automatic expect_rd(input logic [5:0] a, input logic [7:0] e);
        u_spi_host.xfer({`OPC_READ, a}, 16'h0000, 1, r);
        chk(r, {8'h00, e});
    endtask

    task automatic final_report;
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Roughly 48 frames of 3 us each; about three times that before declaring a hang
    initial begin
        #400_000;
        n_fail++;
        final_report;
    end

    initial begin
        step(3);
        rst = 1'b0;
        step(3);
        chk(16'({on1, on2}), 16'h0000);
        u_spi_host.xfer({`OPC_READ, `ADDR_LAST}, 16'h0000, 2, r);
        chk(r, 16'h0003);
        expect_rd(`ADDR_STATUS_B, 8'h00);
        foreach (tbl[i]) expect_rd(tbl[i][13:8], tbl[i][7:0]);
        en1 = 1'b1;
        en2 = 1'b1;
        step(10);
        chk(16'({on1, on2}), 16'h0000);
        reg_wr(`ADDR_DISABLE, 8'h00);
        step(10);
        chk(16'({on1, on2}), 16'h0003);
        for (int i = 0; i < 6; i++) begin
            cause[i] = 1'b1;
            step(6);
            chk(16'({on1, on2}), 16'h0000);
            expect_rd(`ADDR_STATUS_A, 8'h04 << i);
            cause[i] = 1'b0;
            step(2);
            expect_rd(`ADDR_STATUS_A, 8'h04 << i);
            expect_rd(`ADDR_STATUS_A, 8'h00);
            step(10);
            chk(16'({on1, on2}), 16'h0003);
        end
        stby = 1'b1;
        step(3);
        stby = 1'b0;
        step(3);
        chk(16'({on1, on2}), 16'h0000);
        expect_rd(`ADDR_STATUS_A, 8'h02);
        step(10);
        chk(16'({on1, on2}), 16'h0003);
        u_spi_host.xfer({`OPC_WRITE, `ADDR_CH1_LIMIT}, 16'h5a44, 2, r);
        step(4);
        chk({lim1, res1}, 16'h5a44);
        // Opcodes 00 and 11 must leave the register untouched
        for (int op = 0; op < 4; op += 3) begin
            u_spi_host.xfer({2'(op), `ADDR_CH1_LIMIT}, 16'h3300, 1, r);
            expect_rd(`ADDR_CH1_LIMIT, 8'h5a);
        end
        reg_wr(`ADDR_STATUS_A, 8'hff);
        expect_rd(`ADDR_STATUS_A, 8'h00);
        u_spi_host.xfer({`OPC_READ, `ADDR_STATUS_B}, 16'h0000, 1, r);
        chk(r & 16'h0011, 16'h0011);
        reg_wr(`ADDR_SENSE, 8'h44);
        reg_wr(`ADDR_CH1_CFG, 8'h14);
        reg_wr(`ADDR_CH2_CFG, 8'h02);
        reg_wr(`ADDR_CH2_RES, 8'h0f);
        reg_wr(`ADDR_CH2_LIMIT, 8'hff);
        reg_wr(`ADDR_COMBINE, 8'h42);
        step(4);
        chk(16'({comb, dbl, sns1, sns2, off1, off2, cap2}), 16'h007d);
        chk(16'(res2), 16'h000f);
        chk(16'({on1, on2}), 16'h0003);
        for (int k = 0; k < 2; k++) begin
            {mopen, iopen} = 2'(k + 1);
            step(4);
            chk(16'({alert_n, on1, on2}), 16'h0000);
            expect_rd(`ADDR_CH1_LIMIT, 8'h5a);
            chk(16'(alert_n), 16'h0000);
            {mopen, iopen} = 2'b00;
            step(4);
        end
        final_report;
    end
endmodule // tb_top
`default_nettype wire
